// >>> ets_pkg.sv
// ============================================================
// Shared constants and types for the event timestamp sample registers.
package ets_pkg;

    // ============================================================
    // Register offsets on the management port (byte addresses).
    localparam logic [15:0] ETS_OFF_S3_SEC = 16'h0570;   // Third capture seconds.
    localparam logic [15:0] ETS_OFF_S3_PHASE = 16'h0574; // Third capture phase slot.
    localparam logic [15:0] ETS_OFF_S4_NS = 16'h0578;    // Fourth capture nanoseconds.
    localparam logic [15:0] ETS_OFF_S4_SEC = 16'h057C;   // Fourth capture seconds.
    localparam logic [15:0] ETS_OFF_S4_PHASE = 16'h0580; // Fourth capture phase slot.
    localparam logic [15:0] ETS_OFF_S5_NS = 16'h0584;    // Fifth capture nanoseconds.

    // ============================================================
    // Field positions and values after reset.
    localparam int ETS_UNIT_PTR_BIT = 8;                 // Unit pointer in the global index word.
    localparam int ETS_EDGE_BIT = 30;                    // Edge polarity in a nanoseconds word.
    localparam int ETS_NS_MSB = 29;                      // Top bit of the nanoseconds field.
    localparam int ETS_PHASE_MSB = 2;                    // Top bit of the phase slot field.
    localparam logic [31:0] ETS_RESET_WORD = 32'h0000_0000; // Every captured word after reset.
    localparam logic [31:0] ETS_UNMAPPED_WORD = 32'h0000_0000; // Answer to an unmapped read.

    // ============================================================
    // Phase slot timing: 8 ns slots inside one 40 ns period of the 25 MHz clock.
    localparam int ETS_SLOT_NS = 8;                      // Width of one slot in ns.
    localparam int ETS_PERIOD_NS = 40;                   // Period of the timing clock in ns.
    localparam int ETS_SLOT_COUNT = ETS_PERIOD_NS / ETS_SLOT_NS; // Slots in one period.
    localparam logic [2:0] ETS_PH_0NS = 3'h0;            // Slot at 0 ns.
    localparam logic [2:0] ETS_PH_8NS = 3'h1;            // Slot at 8 ns.
    localparam logic [2:0] ETS_PH_16NS = 3'h2;           // Slot at 16 ns.
    localparam logic [2:0] ETS_PH_24NS = 3'h3;           // Slot at 24 ns.
    localparam logic [2:0] ETS_PH_32NS = 3'h4;           // Slot at 32 ns.

    // Which captured sample an incoming record belongs to.
    typedef enum logic [1:0] {
        ETS_SEL_THIRD = 2'h0,
        ETS_SEL_FOURTH = 2'h1,
        ETS_SEL_FIFTH = 2'h3,
        ETS_SEL_OTHER = 2'h2
    } ets_sample_e_t;

    // One capture record from the timestamp unit logic.
    typedef struct packed {
        logic valid;            // Record is present this cycle.
        logic unit;             // Timestamp unit that captured it.
        ets_sample_e_t sample;  // Sample number the record fills.
        logic [31:0] seconds;   // Seconds part of the sample time.
        logic [29:0] nanoseconds; // Low word of the sample time in ns.
        logic rising;           // High for a rising edge.
        logic [2:0] slot;       // Index 0 to 4 of the 8 ns slot.
    } ets_capture_t;

    // Captured words held for one timestamp unit.
    typedef struct packed {
        logic [31:0] s3_sec;
        logic [2:0] s3_phase;
        logic [29:0] s4_ns;
        logic s4_edge;
        logic [31:0] s4_sec;
        logic [2:0] s4_phase;
        logic [29:0] s5_ns;
        logic s5_edge;
    } ets_store_t;

    // One management port request.
    typedef struct packed {
        logic rd;               // Read strobe.
        logic wr;               // Write strobe; all words here are read only.
        logic [15:0] addr;      // Byte address.
        logic [31:0] wdata;     // Write data, ignored.
    } ets_mgmt_req_t;

    // Registered read answer.
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } ets_resp_t;

    // Turns a slot index into the phase code; out-of-range slots give the 0 ns code.
    function automatic logic [2:0] ets_phase_code(input logic [2:0] slot);
        logic [2:0] code;
        case (slot)
            3'h0: code = ETS_PH_0NS;
            3'h1: code = ETS_PH_8NS;
            3'h2: code = ETS_PH_16NS;
            3'h3: code = ETS_PH_24NS;
            3'h4: code = ETS_PH_32NS;
            default: code = ETS_PH_0NS;
        endcase
        return code;
    endfunction

endpackage

// >>> ets_sample_store.sv
`timescale 1ns/1ps
// ============================================================
// Holds the third, fourth and fifth captures of one timestamp unit.
module ets_sample_store
    import ets_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ets_capture_t i_capture,
    input wire logic i_unit_hit,
    output ets_store_t o_store
);

    ets_store_t store_reg;  // All state of this unit.
    ets_store_t store_next; // Next value of the state.
    logic take;             // A record for this unit arrives.

    assign take = i_capture.valid && i_unit_hit;

    // ============================================================
    // Next state: only a capture record changes a word; nothing else can.
    always_comb begin
        store_next = store_reg;
        if (take) begin
            case (i_capture.sample)
                ETS_SEL_THIRD: begin
                    store_next.s3_sec = i_capture.seconds;
                    store_next.s3_phase = ets_phase_code(i_capture.slot);
                end
                ETS_SEL_FOURTH: begin
                    store_next.s4_ns = i_capture.nanoseconds;
                    store_next.s4_edge = i_capture.rising;
                    store_next.s4_sec = i_capture.seconds;
                    store_next.s4_phase = ets_phase_code(i_capture.slot);
                end
                ETS_SEL_FIFTH: begin
                    store_next.s5_ns = i_capture.nanoseconds;
                    store_next.s5_edge = i_capture.rising;
                end
                default: begin
                    // Other samples belong to neighbouring registers.
                    store_next = store_reg;
                end
            endcase
        end
    end

    // Registers the state; every word clears to zero on reset.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            store_reg <= ets_store_t'(0);
        end else begin
            store_reg <= store_next;
        end
    end

    assign o_store = store_reg;

    // ============================================================
    // Checks on the captured words.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence third_take_s;
        take && i_capture.sample == ETS_SEL_THIRD;
    endsequence

    third_sec_a: assert property (third_take_s |=> store_reg.s3_sec == $past(i_capture.seconds))
        else $error("third capture seconds not stored");
    fourth_edge_a: assert property (take && i_capture.sample == ETS_SEL_FOURTH
        |=> store_reg.s4_edge == $past(i_capture.rising)
            && store_reg.s4_ns == $past(i_capture.nanoseconds))
        else $error("fourth capture edge or nanoseconds wrong");
    phase_16ns_a: assert property (third_take_s ##0 (i_capture.slot == 3'h2)
        |=> store_reg.s3_phase == 3'h2)
        else $error("16 ns slot not coded as 010");
    phase_range_a: assert property (store_reg.s4_phase <= 3'h4 && store_reg.s3_phase <= 3'h4)
        else $error("phase code in reserved range");
    store_hold_a: assert property (!take |=> $stable(store_reg))
        else $error("store changed without a capture");

endmodule

// >>> ets_sample_regs.sv
`timescale 1ns/1ps
// ============================================================
// Read-only capture registers for the third to fifth samples of the
// event timestamp input, one set per timestamp unit.
module ets_sample_regs
    import ets_pkg::*;
#(
    parameter int N_UNITS = 2  // Units the one-bit pointer can select.
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [31:0] i_unit_index_reg,
    input wire ets_capture_t i_capture,
    input wire ets_mgmt_req_t i_req,
    output logic o_rd_valid,
    output logic [31:0] o_rdata
);

    // ============================================================
    // Parameter check.
    if (N_UNITS < 1 || N_UNITS > 2) begin : g_bad_units
        $error("N_UNITS must be 1 or 2 for a one-bit unit pointer");
    end

    ets_store_t stores [N_UNITS]; // Captured words of each unit.
    ets_store_t sel_store;        // Words of the unit the pointer selects.
    logic unit_sel;               // Current unit pointer.
    logic [31:0] rd_word;         // Decoded word for the current address.
    ets_resp_t resp_reg;          // All state of this module.
    ets_resp_t resp_next;         // Next value of the state.

    // ============================================================
    // One store per unit; a record goes only to the unit it names.
    for (genvar u = 0; u < N_UNITS; u++) begin : g_unit
        ets_sample_store u_store (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_capture(i_capture),
            .i_unit_hit(i_capture.unit == 1'(u)),
            .o_store(stores[u])
        );
    end

    // ============================================================
    // Unit selection from the global index word.
    assign unit_sel = i_unit_index_reg[ETS_UNIT_PTR_BIT];

    // Picks the selected unit; a pointer past the last unit shows zeros.
    always_comb begin
        sel_store = ets_store_t'(0);
        for (int k = 0; k < N_UNITS; k++) begin
            if (unit_sel == 1'(k)) begin
                sel_store = stores[k];
            end
        end
    end

    // ============================================================
    // Address decode; reserved bits are filled with zeros.
    always_comb begin
        case (i_req.addr)
            ETS_OFF_S3_SEC: begin
                rd_word = sel_store.s3_sec;
            end
            ETS_OFF_S3_PHASE: begin
                rd_word = {29'h0000000, sel_store.s3_phase};
            end
            ETS_OFF_S4_NS: begin
                rd_word = {1'b0, sel_store.s4_edge, sel_store.s4_ns};
            end
            ETS_OFF_S4_SEC: begin
                rd_word = sel_store.s4_sec;
            end
            ETS_OFF_S4_PHASE: begin
                rd_word = {29'h0000000, sel_store.s4_phase};
            end
            ETS_OFF_S5_NS: begin
                rd_word = {1'b0, sel_store.s5_edge, sel_store.s5_ns};
            end
            default: begin
                rd_word = ETS_UNMAPPED_WORD;
            end
        endcase
    end

    // ============================================================
    // Next state: a read answers on the next cycle; writes are dropped.
    always_comb begin
        resp_next = resp_reg;
        resp_next.valid = i_req.rd;
        if (i_req.rd) begin
            resp_next.data = rd_word;
        end
    end

    // Registers the answer; it clears on reset.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            resp_reg <= ets_resp_t'(0);
        end else begin
            resp_reg <= resp_next;
        end
    end

    assign o_rd_valid = resp_reg.valid;
    assign o_rdata = resp_reg.data;

    // ============================================================
    // Checks on the read path.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence read_at_s(logic [15:0] off);
        i_req.rd && i_req.addr == off;
    endsequence

    read_latency_a: assert property (i_req.rd |=> o_rd_valid ##1 (o_rd_valid == $past(i_req.rd)))
        else $error("read answer not one cycle after request");
    third_sec_rd_a: assert property (read_at_s(16'h0570)
        |=> o_rdata == $past(sel_store.s3_sec))
        else $error("third seconds read wrong");
    unit_ptr_a: assert property (read_at_s(16'h057C) ##0 (i_unit_index_reg[8] == 1'b0)
        |=> o_rdata == $past(stores[0].s4_sec))
        else $error("unit pointer selects wrong unit");
    phase_rsvd_a: assert property ((read_at_s(16'h0574) or read_at_s(16'h0580))
        |=> o_rdata[31:3] == 29'h0000000)
        else $error("phase reserved bits not zero");
    ns_layout_a: assert property (read_at_s(16'h0584)
        |=> !o_rdata[31] && o_rdata[30] == $past(sel_store.s5_edge)
            && o_rdata[29:0] == $past(sel_store.s5_ns))
        else $error("fifth nanoseconds layout wrong");
    edge_rd_a: assert property (read_at_s(16'h0578)
        |=> o_rdata[30] == $past(sel_store.s4_edge))
        else $error("fourth edge flag read wrong");
    write_noeff_a: assert property (i_req.wr && !i_capture.valid
        |=> stores[0] == $past(stores[0]))
        else $error("write changed a captured word");
    unmapped_a: assert property (read_at_s(16'h0588) |=> o_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule

// >>> ets_event_source.sv
`timescale 1ns/1ps
// ============================================================
// Event source model: turns one command into a one-cycle capture record.
module ets_event_source
    import ets_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_fire,
    input wire ets_capture_t i_rec,
    output ets_capture_t o_capture
);
    // Registers the record for one cycle. Between records the fields flip every cycle,
    // so a stale record can never be taken for fresh data.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_capture <= '0;
        end else if (i_fire) begin
            o_capture <= i_rec;
            o_capture.valid <= 1'b1;
        end else begin
            o_capture <= ~o_capture;
            o_capture.valid <= 1'b0;
        end
    end
endmodule

// >>> test_event_timestamp_sample_regs.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the capture sample registers.
module test_event_timestamp_sample_regs;
    import ets_pkg::*;

    // Compares a design value with the expected one and counts the result.
    `define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
        $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

    logic i_clk;                  // Bench clock.
    logic i_rst;                  // Asynchronous reset.
    logic [31:0] unit_idx;        // Global unit index word.
    ets_mgmt_req_t req;           // Management port request.
    logic fire;                   // Command to the event source.
    ets_capture_t rec;            // Record handed to the event source.
    ets_capture_t cap;            // Record from the event source.
    logic rd_valid;               // Read answer valid.
    logic [31:0] rdata;           // Read answer data.
    int error_cnt;                // Mismatches seen.
    int check_count;              // Comparisons made.
    ets_capture_t r;              // Scratch record.

    // Expected contents, one entry per unit.
    logic [31:0] s3s[2];
    logic [31:0] s4s[2];
    logic [2:0] s3p[2];
    logic [2:0] s4p[2];
    logic [29:0] s4n[2];
    logic [29:0] s5n[2];
    logic s4e[2];
    logic s5e[2];
    // The six mapped words and one unmapped neighbour.
    logic [15:0] adr[7] = '{16'h0570, 16'h0574, 16'h0578, 16'h057C, 16'h0580, 16'h0584, 16'h056C};

    ets_event_source ets_event_source_i (.i_clk(i_clk), .i_rst(i_rst), .i_fire(fire),
        .i_rec(rec), .o_capture(cap));
    ets_sample_regs #(.N_UNITS(2)) ets_sample_regs_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_unit_index_reg(unit_idx), .i_capture(cap), .i_req(req), .o_rd_valid(rd_valid),
        .o_rdata(rdata));

    // Makes the 50 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // Phase code of a slot; slots past the last one fall back to the 0 ns code.
    function automatic logic [2:0] ph(input logic [2:0] s);
        return (s > 3'h4) ? 3'h0 : s;
    endfunction

    // Word a read of address a should return for unit u.
    function automatic logic [31:0] exp_word(input logic u, input logic [15:0] a);
        case (a)
            16'h0570: return s3s[u];
            16'h0574: return {29'h0, s3p[u]};
            16'h0578: return {1'b0, s4e[u], s4n[u]};
            16'h057C: return s4s[u];
            16'h0580: return {29'h0, s4p[u]};
            16'h0584: return {1'b0, s5e[u], s5n[u]};
            default: return 32'h0;
        endcase
    endfunction

    // Draws a random capture record, out-of-range slots and ignored samples included.
    function automatic ets_capture_t rand_rec();
        ets_capture_t x;
        x.valid = 1'b1;
        x.unit = 1'($urandom_range(0, 1));
        x.sample = ets_sample_e_t'($urandom_range(0, 3));
        x.seconds = $urandom;
        x.nanoseconds = 30'($urandom);
        x.rising = 1'($urandom_range(0, 1));
        x.slot = 3'($urandom_range(0, 7));
        return x;
    endfunction

    // Clears the expected contents, as a reset does.
    task automatic clear_model();
        for (int u = 0; u < 2; u++) begin
            {s3s[u], s4s[u], s3p[u], s4p[u], s4n[u], s5n[u], s4e[u], s5e[u]} = '0;
        end
    endtask

    // Sends one record; a random write lands in the capture cycle and must not act.
    task automatic send(input ets_capture_t x);
        @(posedge i_clk);
        fire <= 1'b1;
        rec <= x;
        @(posedge i_clk);
        fire <= 1'b0;
        req.wr <= 1'b1;
        req.addr <= adr[$urandom_range(0, 5)];
        req.wdata <= $urandom;
        @(posedge i_clk);
        req.wr <= 1'b0;
        case (x.sample)
            ETS_SEL_THIRD: begin
                s3s[x.unit] = x.seconds;
                s3p[x.unit] = ph(x.slot);
            end
            ETS_SEL_FOURTH: begin
                s4s[x.unit] = x.seconds;
                s4p[x.unit] = ph(x.slot);
                s4n[x.unit] = x.nanoseconds;
                s4e[x.unit] = x.rising;
            end
            ETS_SEL_FIFTH: begin
                s5n[x.unit] = x.nanoseconds;
                s5e[x.unit] = x.rising;
            end
            default: begin
            end
        endcase
    endtask

    // Reads every word back to back for unit u; the other index bits are random.
    task automatic sweep(input logic u);
        logic [31:0] idx;
        for (int i = 0; i <= 7; i++) begin
            @(posedge i_clk);
            idx = $urandom;
            idx[8] = u;
            unit_idx <= idx;
            req.rd <= (i < 7);
            req.addr <= adr[i % 7];
            #1;
            if (i > 0) begin
                `CHK(rd_valid, 1'b1)
                `CHK(rdata, exp_word(u, adr[i - 1]))
            end
        end
        @(posedge i_clk);
        #1;
        `CHK(rd_valid, 1'b0)
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        i_rst = 1'b1;
        unit_idx = 32'h0;
        req = '0;
        fire = 1'b0;
        rec = '0;
        error_cnt = 0;
        check_count = 0;
        clear_model();
        void'($urandom(32'hADD88344));
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        sweep(1'b0);
        sweep(1'b1);
        // Every slot index, the out-of-range ones too, into the third sample.
        for (int s = 0; s < 8; s++) begin
            r = rand_rec();
            r.unit = 1'b0;
            r.sample = ETS_SEL_THIRD;
            r.slot = 3'(s);
            send(r);
            sweep(1'b0);
        end
        repeat (40) begin
            r = rand_rec();
            send(r);
            sweep(1'($urandom_range(0, 1)));
        end
        // A second reset in mid-run must clear every word.
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        clear_model();
        sweep(1'b0);
        sweep(1'b1);
        complete_run();
    end
endmodule
